// >>> src/irc_cfg_field.sv
// one write-enable gated configuration field
`timescale 1ns/1ps
`default_nettype none
module irc_cfg_field #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic         upd,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] q
);
  logic [W-1:0] next_q;

  always_comb begin
    next_q = q;
    if (ce && upd) begin
      next_q = din;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= RST;
    end else begin
      q <= next_q;
    end
  end

  chk_field_reset: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> q == RST)
    else $error("field not at reset value after reset");
endmodule
`default_nettype wire

// >>> src/irc_line_cfg.sv
// line request configuration register with axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
module irc_line_cfg
  import irc_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [STRB_W-1:0] s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [DATA_W-1:0] s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              req_line,
  output var  logic              line_enable,
  output var  logic              line_target,
  output var  logic [PRIO_W-1:0] line_priority,
  output var  logic              line_active_low,
  output var  logic              line_asserted,
  output var  logic              normal_irq_req,
  output var  logic              fast_irq_req
);
  // write channel holding state
  logic              aw_full;
  logic              w_full;
  logic [ADDR_W-1:0] aw_addr;
  logic [DATA_W-1:0] w_data;
  logic [STRB_W-1:0] w_strb;
  logic              next_aw_full;
  logic              next_w_full;
  logic [ADDR_W-1:0] next_aw_addr;
  logic [DATA_W-1:0] next_w_data;
  logic [STRB_W-1:0] next_w_strb;
  logic              next_awready;
  logic              next_wready;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              do_wr;
  logic              wr_hit;

  // read channel state
  irc_rd_state_e     rd_state;
  irc_rd_state_e     next_rd_state;
  logic              next_arready;
  logic              next_rvalid;
  logic [DATA_W-1:0] next_rdata;
  logic [1:0]        next_rresp;
  logic [DATA_W-1:0] cfg_view;

  // field update strobes
  logic upd_prio;
  logic upd_tgt;
  logic upd_en;
  logic upd_pol;
  logic we_lane;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = (a[ADDR_W-1:2] == CFG_OFFSET[ADDR_W-1:2]);
  endfunction

  always_comb begin
    next_aw_full = aw_full;
    next_w_full  = w_full;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    do_wr        = 1'b0;
    wr_hit       = addr_hit(aw_addr);
    if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        next_aw_full = 1'b1;
        next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        next_w_full = 1'b1;
        next_w_data = s_axi_wdata;
        next_w_strb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        next_bvalid = 1'b0;
      end
      if (aw_full && w_full && !s_axi_bvalid) begin
        do_wr        = 1'b1;
        next_aw_full = 1'b0;
        next_w_full  = 1'b0;
        next_bvalid  = 1'b1;
        next_bresp   = wr_hit ? RESP_OKAY : RESP_DECERR;
      end
    end
    next_awready = !next_aw_full && !next_bvalid;
    next_wready  = !next_w_full && !next_bvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      aw_full       <= next_aw_full;
      w_full        <= next_w_full;
      aw_addr       <= next_aw_addr;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
    end
  end

  // a field moves only when its write-enable bit and both lanes are written
  always_comb begin
    we_lane  = do_wr && wr_hit && w_strb[WE_PRIO_BIT / 8];
    upd_prio = we_lane && w_data[WE_PRIO_BIT]
               && w_strb[PRIO_LSB / 8];
    upd_tgt  = we_lane && w_data[WE_TGT_BIT]
               && w_strb[TGT_BIT / 8];
    upd_en   = we_lane && w_data[WE_EN_BIT]
               && w_strb[EN_BIT / 8];
    upd_pol  = we_lane && w_data[WE_POL_BIT]
               && w_strb[POL_BIT / 8];
  end

  irc_cfg_field #(.W(PRIO_W), .RST(PRIO_RST)) u_prio (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .upd     (upd_prio),
    .din     (w_data[PRIO_LSB +: PRIO_W]),
    .q       (line_priority)
  );

  irc_cfg_field #(.W(1), .RST(TGT_RST)) u_tgt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .upd     (upd_tgt),
    .din     (w_data[TGT_BIT]),
    .q       (line_target)
  );

  irc_cfg_field #(.W(1), .RST(EN_RST)) u_en (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .upd     (upd_en),
    .din     (w_data[EN_BIT]),
    .q       (line_enable)
  );

  irc_cfg_field #(.W(1), .RST(POL_RST)) u_pol (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .upd     (upd_pol),
    .din     (w_data[POL_BIT]),
    .q       (line_active_low)
  );

  irc_req_route u_route (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .ce             (ce),
    .req_line       (req_line),
    .active_low     (line_active_low),
    .enable         (line_enable),
    .target         (line_target),
    .priority_level (line_priority),
    .req_active     (line_asserted),
    .normal_req     (normal_irq_req),
    .fast_req       (fast_irq_req)
  );

  // read view: write enables and reserved bits are zero
  always_comb begin
    cfg_view                        = '0;
    cfg_view[PRIO_LSB +: PRIO_W]    = line_priority;
    cfg_view[TGT_BIT]               = line_target;
    cfg_view[EN_BIT]                = line_enable;
    cfg_view[POL_BIT]               = line_active_low;
  end

  always_comb begin
    next_rd_state = rd_state;
    next_arready  = s_axi_arready;
    next_rvalid   = s_axi_rvalid;
    next_rdata    = s_axi_rdata;
    next_rresp    = s_axi_rresp;
    if (ce) begin
      case (rd_state)
        IRC_RD_IDLE: begin
          next_arready = 1'b1;
          if (s_axi_arvalid && s_axi_arready) begin
            next_rd_state = IRC_RD_DATA;
            next_arready  = 1'b0;
            next_rvalid   = 1'b1;
            if (addr_hit(s_axi_araddr)) begin
              next_rdata = cfg_view;
              next_rresp = RESP_OKAY;
            end else begin
              next_rdata = '0;
              next_rresp = RESP_DECERR;
            end
          end
        end
        IRC_RD_DATA: begin
          if (s_axi_rready) begin
            next_rd_state = IRC_RD_IDLE;
            next_rvalid   = 1'b0;
            next_arready  = 1'b1;
          end
        end
        default: begin
          next_rd_state = IRC_RD_IDLE;
          next_rvalid   = 1'b0;
          next_arready  = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state      <= IRC_RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      rd_state      <= next_rd_state;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_cfg_write;
    do_wr && wr_hit && w_strb[WE_PRIO_BIT / 8];
  endsequence

  chk_prio_update: assert property (
    s_cfg_write and (w_data[WE_PRIO_BIT] && w_strb[PRIO_LSB / 8])
    |=> line_priority == $past(w_data[PRIO_LSB +: PRIO_W]))
    else $error("priority did not take written value");
  chk_prio_keep: assert property (
    do_wr && !w_data[WE_PRIO_BIT] |=> $stable(line_priority))
    else $error("priority changed without write enable");
  chk_tgt_keep: assert property (
    do_wr && !w_data[WE_TGT_BIT] |=> $stable(line_target))
    else $error("target changed without write enable");
  chk_en_keep: assert property (
    do_wr && !w_data[WE_EN_BIT] |=> $stable(line_enable))
    else $error("enable changed without write enable");
  chk_pol_keep: assert property (
    do_wr && !w_data[WE_POL_BIT] |=> $stable(line_active_low))
    else $error("polarity changed without write enable");
  chk_fields_idle: assert property (
    !do_wr |=> $stable({line_priority, line_target,
                        line_enable, line_active_low}))
    else $error("field changed with no write");
  chk_rd_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[TOP_BIT:RESV_LSB] == '0)
    else $error("write-enable or reserved bits read nonzero");
  chk_wr_resp: assert property (
    ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    ##1 ce |=> s_axi_bvalid)
    else $error("write response missing");
  chk_rd_resp: assert property (
    ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0
    (s_axi_rdata == $past(cfg_view)
     || s_axi_rresp == RESP_DECERR))
    else $error("read data or response wrong");
endmodule
`default_nettype wire

// >>> src/irc_pkg.sv
// constants of the interrupt line configuration register block
package irc_pkg;
  localparam int          ADDR_W      = 12;
  localparam int          DATA_W      = 32;
  localparam int          STRB_W      = DATA_W / 8;
  localparam logic [11:0] CFG_OFFSET  = 12'h000;
  localparam int          PRIO_LSB    = 0;
  localparam int          PRIO_W      = 4;
  localparam int          TGT_BIT     = 8;
  localparam int          EN_BIT      = 16;
  localparam int          POL_BIT     = 17;
  localparam int          RESV_LSB    = 18;
  localparam int          RESV_MSB    = 24;
  localparam int          WE_POL_BIT  = 25;
  localparam int          WE_EN_BIT   = 26;
  localparam int          WE_TGT_BIT  = 27;
  localparam int          WE_PRIO_BIT = 28;
  localparam int          TOP_BIT     = 31;
  localparam logic [3:0]  PRIO_RST    = 4'h0;
  localparam logic [3:0]  PRIO_MASKED = 4'h0;
  localparam logic        TGT_RST     = 1'h0;
  localparam logic        EN_RST      = 1'h0;
  localparam logic        POL_RST     = 1'h0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_DECERR = 2'h3;

  typedef enum logic {
    IRC_RD_IDLE,
    IRC_RD_DATA
  } irc_rd_state_e;
endpackage

// >>> src/irc_req_route.sv
// request line qualification and routing to normal or fast output
`timescale 1ns/1ps
`default_nettype none
module irc_req_route
  import irc_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic              req_line,
  input  wire logic              active_low,
  input  wire logic              enable,
  input  wire logic              target,
  input  wire logic [PRIO_W-1:0] priority_level,
  output var  logic              req_active,
  output var  logic              normal_req,
  output var  logic              fast_req
);
  logic next_active;
  logic next_normal;
  logic next_fast;
  logic qualified;

  always_comb begin
    next_active = req_active;
    next_normal = normal_req;
    next_fast   = fast_req;
    qualified   = 1'b0;
    if (ce) begin
      next_active = req_line ^ active_low;
      qualified   = next_active && enable
                    && (priority_level != PRIO_MASKED);
      next_normal = qualified && target;
      next_fast   = qualified && !target;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_active <= 1'b0;
      normal_req <= 1'b0;
      fast_req   <= 1'b0;
    end else begin
      req_active <= next_active;
      normal_req <= next_normal;
      fast_req   <= next_fast;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_low_active: assert property (
    aresetn && ce && active_low |=> req_active == !$past(req_line))
    else $error("active low line not seen as asserted when low");
  chk_high_active: assert property (
    aresetn && ce && !active_low |=> req_active == $past(req_line))
    else $error("active high line not followed");
  chk_discard_off: assert property (
    ce && !enable |=> !normal_req && !fast_req)
    else $error("disabled request reached an output");
  chk_prio_mask: assert property (
    ce && priority_level == PRIO_MASKED |=> !normal_req && !fast_req)
    else $error("priority zero did not mask request");
  chk_route_sel: assert property (
    ce && enable && priority_level != PRIO_MASKED
    && (req_line ^ active_low)
    |=> (normal_req == $past(target)) && (fast_req == !$past(target)))
    else $error("request routed to wrong output");
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench for the line request configuration register
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import irc_pkg::*;
;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic              awvalid = 1'b0;
  logic              awready;
  logic [DATA_W-1:0] wdata = '0;
  logic [STRB_W-1:0] wstrb = '0;
  logic              wvalid = 1'b0;
  logic              wready;
  logic [1:0]        bresp;
  logic              bvalid;
  logic              bready = 1'b0;
  logic [ADDR_W-1:0] araddr = '0;
  logic              arvalid = 1'b0;
  logic              arready;
  logic [DATA_W-1:0] rdata;
  logic [1:0]        rresp;
  logic              rvalid;
  logic              rready = 1'b0;
  logic              req_line = 1'b0;
  logic              ce = 1'b1;
  logic              en, tgt, pol, asrt, nrq, frq;
  logic [PRIO_W-1:0] prio;
  logic [31:0]       d;
  logic [1:0]        r;
  int                err_count = 0;
  int                checked = 0;
  int                cycles = 0;
  logic [31:0] wr_tbl [8] = '{32'h0000_000f, 32'h1000_0005, 32'h0000_010a,
    32'h0800_0100, 32'h0401_0000, 32'h0002_0000, 32'h0202_0000,
    32'h1000_0000};
  logic [31:0] ex_tbl [8] = '{32'h0000_0000, 32'h0000_0005, 32'h0000_0005,
    32'h0000_0105, 32'h0001_0105, 32'h0001_0105, 32'h0003_0105,
    32'h0003_0100};

  always #12.5 aclk = ~aclk;

  irc_line_cfg i_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .req_line(req_line), .line_enable(en),
    .line_target(tgt), .line_priority(prio), .line_active_low(pol),
    .line_asserted(asrt), .normal_irq_req(nrq), .fast_irq_req(frq)
  );

  task automatic complete_run;
    if (err_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end

  // ready and valid are sampled at the falling edge, stable until the take
  task automatic axi_write(input logic [11:0] a, input logic [31:0] dv,
                           input logic [3:0] s, output logic [1:0] rs);
    logic aw_ok, w_ok, got;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    got = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= dv;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(negedge aclk);
      got = !aw_ok && awready === 1'b1;
      w_ok = w_ok || wready === 1'b1;
      @(posedge aclk);
      if (got) begin
        awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (w_ok) wvalid <= 1'b0;
    end
    do begin
      @(negedge aclk);
    end while (bvalid !== 1'b1);
    rs = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] dv,
                          output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
    end while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do begin
      @(negedge aclk);
    end while (rvalid !== 1'b1);
    dv = rdata;
    rs = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  task automatic wr_ok(input logic [31:0] dv);
    axi_write(CFG_OFFSET, dv, 4'hf, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic rd_chk(input logic [31:0] exp);
    axi_read(CFG_OFFSET, d, r);
    check(d, exp);
    check({25'h0, pol, en, tgt, prio}, {25'h0, exp[17:16], exp[8], exp[3:0]});
  endtask

  // drive the raw line, then look at asserted, normal and fast outputs
  task automatic req_chk(input logic v, input logic [2:0] exp);
    @(posedge aclk);
    req_line <= v;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    check({29'h0, asrt, nrq, frq}, {29'h0, exp});
  endtask

  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask

  initial begin
    do_reset();
    rd_chk(32'h0);
    // reserved bits are never written by software here
    for (int i = 0; i < 8; i++) begin
      wr_ok(wr_tbl[i]);
      rd_chk(ex_tbl[i]);
    end
    req_chk(1'b0, 3'b100);
    wr_ok(32'h1000_000f);
    req_chk(1'b0, 3'b110);
    req_chk(1'b1, 3'b000);
    wr_ok(32'h0400_0000);
    req_chk(1'b0, 3'b100);
    wr_ok(32'h0800_0000);
    rd_chk(32'h0002_000f);
    wr_ok(32'h0401_0000);
    req_chk(1'b0, 3'b101);
    wr_ok(32'h0200_0000);
    req_chk(1'b1, 3'b101);
    req_chk(1'b0, 3'b000);
    axi_write(12'h004, 32'h1000_0003, 4'hf, r);
    check({30'h0, r}, {30'h0, RESP_DECERR});
    axi_read(12'h004, d, r);
    check(d, 32'h0);
    check({30'h0, r}, {30'h0, RESP_DECERR});
    axi_write(CFG_OFFSET, 32'h1000_0001, 4'h7, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
    rd_chk(32'h0001_000f);
    wr_ok(32'h0400_0000);
    wr_ok(32'h1a02_0107);
    wr_ok(32'h0401_0000);
    rd_chk(32'h0003_0107);
    // clock enable low freezes the request path
    @(posedge aclk);
    ce <= 1'b0;
    req_line <= 1'b1;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    check({29'h0, asrt, nrq, frq}, 32'h0000_0006);
    @(posedge aclk);
    ce <= 1'b1;
    req_chk(1'b1, 3'b000);
    do_reset();
    rd_chk(32'h0);
    req_chk(1'b1, 3'b100);
    complete_run();
  end
endmodule
`default_nettype wire
